// ===== verification/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // Serial link
  output logic     sck_out,
  output logic     cs_n_out,
  output logic     mosi_out,
  input  wire logic miso_in
);
  logic [7:0] tx_buf [0:3];
  logic [7:0] rx_buf [0:3];

  // Rising select after time zero clears the link bit counter for sure
  initial begin
    sck_out  = 1'b0;
    cs_n_out = 1'b0;
    mosi_out = 1'b0;
    #1 cs_n_out = 1'b1;
  end

  // ****************************************
  // One frame, mode 0, 32 ns clock
  // ****************************************
  task automatic frame(input int n);
    cs_n_out = 1'b0;
    #20;
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        mosi_out = tx_buf[b][i];
        #16 sck_out = 1'b1;
        rx_buf[b][i] = miso_in;
        #16 sck_out = 1'b0;
      end
    end
    #10 cs_n_out = 1'b1;
    // Released line must not keep its last value
    mosi_out = ~mosi_out;
    #100;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_top;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic pay_ready = 1'b0;
  logic [2:0] evt = 3'h0;
  logic sck, cs_n, mosi, miso, pay_valid, irq_n, power_up, primary_rx, crc_en, crc_two, bank;
  logic [5:0] auto_acknowledge_en, rx_pipe_en;
  radio_cmd_pkg::pay_word_s pay_word;
  radio_cmd_pkg::pay_word_s words[$];
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  spi_host_model host_u (.sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));

  radio_spi_command_config #(.FIFO_DEPTH(8)) dut_u (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .spi_sck_in(sck), .spi_cs_n_in(cs_n),
    .spi_mosi_in(mosi), .spi_miso_out(miso), .rx_ready_evt_in(evt[2]), .tx_sent_evt_in(evt[1]),
    .retry_evt_in(evt[0]), .rx_pipe_in(3'h7), .rx_width_in(8'h1D), .pay_valid_out(pay_valid),
    .pay_word_out(pay_word), .pay_ready_in(pay_ready), .irq_n_out(irq_n), .power_up_out(power_up),
    .primary_rx_out(primary_rx), .crc_enable_out(crc_en), .crc_two_byte_out(crc_two),
    .auto_acknowledge_enable_out(auto_acknowledge_en), .rx_pipe_enable_out(rx_pipe_en), .bank_out(bank));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic close_out();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 50000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic spi(input logic [7:0] c, d0, d1, d2, input int n);
    host_u.tx_buf[0] = c;
    host_u.tx_buf[1] = d0;
    host_u.tx_buf[2] = d1;
    host_u.tx_buf[3] = d2;
    host_u.frame(n);
  endtask

  task automatic wr(input logic [7:0] a, d);
    spi(8'h20 | a, d, 8'h00, 8'h00, 2);
  endtask

  task automatic rd(input logic [7:0] c, exp);
    spi(c, 8'hFF, 8'h00, 8'h00, 2);
    `CHK(host_u.rx_buf[1], exp)
  endtask

  // Stalls the stream while frames load, then drains it
  task automatic drain(input int n);
    words.delete();
    @(posedge clk_sys_in) #1 pay_ready = 1'b1;
    repeat (40) begin
      @(negedge clk_sys_in);
      if (pay_valid === 1'b1) words.push_back(pay_word);
    end
    @(posedge clk_sys_in) #1 pay_ready = 1'b0;
    `CHK(words.size(), n)
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (8) @(posedge clk_sys_in);
    #1 reset_in = 1'b0;
    repeat (4) @(posedge clk_sys_in);
    `CHK({crc_en, crc_two, power_up, primary_rx, irq_n, bank}, 6'b10_0010)
    `CHK({auto_acknowledge_en, rx_pipe_en}, 12'hFC3)
    rd(8'h00, 8'h08);
    rd(8'h01, 8'h3F);
    rd(8'h02, 8'h03);
    spi(8'hFF, 8'h00, 8'h00, 8'h00, 1);
    `CHK(host_u.rx_buf[0], 8'h0E)
    rd(8'h60, 8'h00);
    spi(8'hB0, 8'h55, 8'h00, 8'h00, 2);
    drain(0);
    spi(8'h50, 8'h73, 8'h00, 8'h00, 2);
    rd(8'h60, 8'h1D);
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, 8'h0A | (8'h40 >> i));
      @(posedge clk_sys_in) #1 evt = 3'h4 >> i;
      @(posedge clk_sys_in) #1 evt = 3'h0;
      repeat (4) @(posedge clk_sys_in);
      `CHK(irq_n, 1'b1)
      wr(8'h00, 8'h0A);
      `CHK(irq_n, 1'b0)
      `CHK(power_up, 1'b1)
      wr(8'h07, 8'h70);
      `CHK(irq_n, 1'b1)
    end
    wr(8'h01, 8'hC0);
    rd(8'h01, 8'h00);
    wr(8'h00, 8'h06);
    `CHK({crc_en, crc_two}, 2'b01)
    wr(8'h01, 8'h01);
    `CHK(crc_en, 1'b1)
    spi(8'hB0, 8'h11, 8'h22, 8'h33, 4);
    drain(3);
    for (int i = 0; i < 3; i++) begin
      `CHK({words[i].data, words[i].noack, words[i].last}, {8'(8'h11 * (i + 1)), 1'b1, i == 2})
    end
    wr(8'h00, 8'h07);
    `CHK(primary_rx, 1'b1)
    spi(8'hAA, 8'hC1, 8'hC2, 8'h00, 3);
    spi(8'hAE, 8'h99, 8'h00, 8'h00, 2);
    spi(8'hAD, 8'hD5, 8'h00, 8'h00, 2);
    drain(3);
    `CHK({words[0].data, words[0].pipe, words[0].ack}, {8'hC1, 3'h2, 1'b1})
    `CHK({words[1].data, words[1].last}, {8'hC2, 1'b1})
    `CHK({words[2].data, words[2].pipe}, {8'hD5, 3'h5})
    for (int i = 1; i < 5; i++) spi(8'hA9, 8'hE0 + i[7:0], 8'h00, 8'h00, 2);
    drain(3);
    for (int i = 0; i < 3; i++) begin
      `CHK(words[i].data, 8'hE1 + i[7:0])
    end
    spi(8'h50, 8'h53, 8'h00, 8'h00, 2);
    `CHK(bank, 1'b1)
    spi(8'hFF, 8'h00, 8'h00, 8'h00, 1);
    `CHK(host_u.rx_buf[0][7], 1'b1)
    wr(8'h00, 8'h00);
    `CHK(power_up, 1'b1)
    spi(8'h50, 8'h53, 8'h00, 8'h00, 2);
    `CHK(bank, 1'b0)
    close_out();
  end
endmodule
`default_nettype wire

// ===== verilog/pay_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module pay_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             reset_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_s;

  fifo_s            st_reg;
  fifo_s            st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             do_wr;
  logic             do_rd;

  always_comb begin
    in_ready_out  = (st_reg.wr[AW] == st_reg.rd[AW]) || (st_reg.wr[AW-1:0] != st_reg.rd[AW-1:0]);
    out_valid_out = st_reg.wr != st_reg.rd;
    out_data_out  = mem[st_reg.rd[AW-1:0]];
    do_wr         = in_valid_in && in_ready_out;
    do_rd         = out_valid_out && out_ready_in;
    st_next       = st_reg;
    if (do_wr) begin
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (do_rd) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
    if (reset_in) begin
      st_next = '0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    st_reg <= st_next;
    if (do_wr) begin
      mem[st_reg.wr[AW-1:0]] <= in_data_in;
    end
  end

endmodule
`default_nettype wire

// ===== verilog/radio_cmd_pkg.sv
`default_nettype none
package radio_cmd_pkg;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_ACTIVATE    = 8'h50;
  localparam logic [7:0] KEY_FEATURES    = 8'h73;
  localparam logic [7:0] KEY_BANK        = 8'h53;
  localparam logic [7:0] CMD_RX_WIDTH    = 8'h60;
  localparam logic [7:0] CMD_TX_PAY      = 8'hA0;
  localparam logic [7:0] CMD_NOACK_TX    = 8'hB0;
  localparam logic [7:0] CMD_STATUS_ONLY = 8'hFF;
  localparam logic [4:0] CMD_ACK_PAY_TOP = 5'h15;
  localparam logic [2:0] CMD_READ_TOP    = 3'h0;
  localparam logic [2:0] CMD_WRITE_TOP   = 3'h1;

  // ****************************************
  // Register offsets, fields, resets
  // ****************************************
  localparam logic [4:0] REG_RADIO_CFG   = 5'h00;
  localparam logic [4:0] REG_AUTO_ACKNOWLEDGE     = 5'h01;
  localparam logic [4:0] REG_RX_PIPES    = 5'h02;
  localparam logic [4:0] REG_STATUS      = 5'h07;
  localparam int         CFG_RX_MASK     = 6;
  localparam int         CFG_TX_MASK     = 5;
  localparam int         CFG_RT_MASK     = 4;
  localparam int         CFG_CRC_EN      = 3;
  localparam int         CFG_CRC_LEN     = 2;
  localparam int         CFG_POWER_UP_BIT      = 1;
  localparam int         CFG_PRIMARY_ROLE_SELECT     = 0;
  localparam int         STAT_BANK       = 7;
  localparam logic [7:0] CFG_RST         = 8'h08;
  localparam logic [7:0] AUTO_ACKNOWLEDGE_RST     = 8'h3F;
  localparam logic [7:0] RX_PIPES_RST    = 8'h03;
  localparam logic [7:0] PIPE_BITS       = 8'h3F;
  localparam logic [2:0] PIPE_LAST_VALID = 3'h5;
  localparam logic [5:0] MAX_PAYLOAD     = 6'h20;
  localparam logic [1:0] MAX_ACK_PENDING = 2'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_DATA = 3'b010,
    PH_SKIP = 3'b100
  } cmd_phase_e;

  typedef struct packed {
    logic [7:0] data;
    logic [2:0] pipe;
    logic       ack;
    logic       noack;
    logic       last;
  } pay_word_s;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] cfg;
    logic [7:0] auto_acknowledge;
    logic [7:0] rx_pipes;
    logic [7:0] width;
    logic       features;
  } snap_s;

endpackage
`default_nettype wire

// ===== verilog/radio_spi_command_config.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: Host opens each command with chip select falling; one command byte, MSB first.
// R2: Status byte shifts out on the serial output alongside the command byte.
// R3: Unlock command plus 0x73 toggles the three optional commands on and off.
// R4: Host issues the unlock command only in power-down or standby.
// R5: Optional commands start off; while off, writes do nothing, reads give zeros.
// R6: Unlock command plus 0x53 toggles the bank; bank shows in status bit 7.
// R7: Width read returns byte count of payload at receive FIFO head.
// R8: Ack payload names pipe 0 to 5 in low bits; 1-32 bytes from byte 0.
// R9: At most three ack payloads pending; same pipe kept first-in first-out.
// R10: No-ack write loads 1-32 bytes, low byte first, packet marked no-ack.
// R11: All-ones command does nothing and takes no data bytes.
// R12: Bank 0 data low byte first; each byte MSB first.
// R13: Config bits 6,5,4 mask the three interrupt sources from the low pin.
// R14: CRC enable resets to 1 and is forced high by any auto-ack bit.
// R15: CRC length bit picks one byte at 0, two bytes at 1; resets 0.
// R16: Bit 1 powers up, bit 0 selects primary receiver; both reset 0.
// R17: Auto-ack bits 5:0 reset to 1; bits 7:6 only ever hold 00.
// R18: Host writes registers only in power-down or standby.
// R19: Ack payload for pipe 6 or 7 is dropped, FIFO untouched.
module radio_spi_command_config #(
  parameter int FIFO_DEPTH = 8
) (
  // System clock and reset
  input  wire logic                      clk_sys_in,
  input  wire logic                      reset_in,
  // Serial link
  input  wire logic                      spi_sck_in,
  input  wire logic                      spi_cs_n_in,
  input  wire logic                      spi_mosi_in,
  output logic                           spi_miso_out,
  // Radio datapath events and state
  input  wire logic                      rx_ready_evt_in,
  input  wire logic                      tx_sent_evt_in,
  input  wire logic                      retry_evt_in,
  input  wire logic [2:0]                rx_pipe_in,
  input  wire logic [7:0]                rx_width_in,
  // Payload stream to the packet engine
  output logic                           pay_valid_out,
  output radio_cmd_pkg::pay_word_s       pay_word_out,
  input  wire logic                      pay_ready_in,
  // Configuration and interrupt
  output logic                           irq_n_out,
  output logic                           power_up_out,
  output logic                           primary_rx_out,
  output logic                           crc_enable_out,
  output logic                           crc_two_byte_out,
  output logic [5:0]                     auto_acknowledge_enable_out,
  output logic [5:0]                     rx_pipe_enable_out,
  output logic                           bank_out
);

  // ****************************************
  // Link side state
  // ****************************************
  typedef struct packed {
    logic [1:0] nbytes;
    logic [2:0] bit_cnt;
    logic [6:0] sh;
    logic [7:0] cmd;
  } link_s;

  typedef struct packed {
    logic [7:0] hold;
    logic       first;
    logic       tgl;
  } hand_s;

  typedef struct packed {
    logic       miso;
    logic [7:0] cur;
  } out_s;

  link_s      lp_reg;
  link_s      lp_next;
  hand_s      rx_reg;
  hand_s      rx_next;
  out_s       ns_reg;
  out_s       ns_next;
  logic [7:0] rx_byte;
  logic [7:0] resp;
  logic       bank_pred;

  // ****************************************
  // System side state
  // ****************************************
  typedef struct packed {
    logic [3:0]                cs_s;
    logic [2:0]                tg_s;
    radio_cmd_pkg::cmd_phase_e phase;
    logic [7:0]                cmd;
    logic [5:0]                dcnt;
    logic                      bank;
    logic                      features;
    logic [7:0]                cfg;
    logic [7:0]                auto_acknowledge;
    logic [7:0]                rx_pipes;
    logic [2:0]                flags;
    logic [1:0]                ack_cnt;
    logic                      stage_v;
    radio_cmd_pkg::pay_word_s  stage;
    logic                      out_v;
    radio_cmd_pkg::pay_word_s  out_w;
    logic                      irq_n;
    radio_cmd_pkg::snap_s      snap;
  } sys_s;

  sys_s                     st_reg;
  sys_s                     st_next;
  logic                     byte_evt;
  logic                     frame_end;
  logic                     is_ack;
  logic                     pay_ok;
  logic                     push;
  radio_cmd_pkg::pay_word_s push_w;
  logic                     f_ready;
  logic                     f_valid;
  radio_cmd_pkg::pay_word_s f_data;
  logic                     f_take;
  logic                     ack_inc;
  logic                     ack_dec;

  pay_fifo #(
    .WIDTH ($bits(radio_cmd_pkg::pay_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .reset_in      (reset_in),
    .in_valid_in   (push),
    .in_ready_out  (f_ready),
    .in_data_in    (push_w),
    .out_valid_out (f_valid),
    .out_ready_in  (f_take),
    .out_data_out  (f_data)
  );

  // ****************************************
  // Link logic on the serial clock
  // ****************************************
  always_comb begin
    lp_next         = lp_reg;
    rx_next         = rx_reg;
    ns_next         = ns_reg;
    rx_byte         = {lp_reg.sh, spi_mosi_in};
    lp_next.bit_cnt = lp_reg.bit_cnt + 3'h1;
    lp_next.sh      = rx_byte[6:0];
    if (lp_reg.bit_cnt == 3'h7) begin
      rx_next.hold  = rx_byte;
      rx_next.first = lp_reg.nbytes == 2'h0;
      rx_next.tgl   = ~rx_reg.tgl;
      if (lp_reg.nbytes != 2'h2) begin
        lp_next.nbytes = lp_reg.nbytes + 2'h1;
      end
      if (lp_reg.nbytes == 2'h0) begin
        lp_next.cmd = rx_byte;
      end
    end
    // Next frame's first bit must already be out when its first edge rises
    bank_pred = st_reg.snap.status[radio_cmd_pkg::STAT_BANK]
              ^ (lp_reg.cmd == radio_cmd_pkg::CMD_ACTIVATE && lp_reg.nbytes == 2'h2
                 && rx_reg.hold == radio_cmd_pkg::KEY_BANK); // R6
    resp = {bank_pred, st_reg.snap.status[6:0]};
    if (lp_reg.nbytes == 2'h1) begin
      if (lp_reg.cmd[7:5] == radio_cmd_pkg::CMD_READ_TOP) begin
        resp = 8'h00;
        if (!st_reg.snap.status[radio_cmd_pkg::STAT_BANK]) begin
          unique case (lp_reg.cmd[4:0])
            radio_cmd_pkg::REG_RADIO_CFG: resp = st_reg.snap.cfg;
            radio_cmd_pkg::REG_AUTO_ACKNOWLEDGE:   resp = st_reg.snap.auto_acknowledge;
            radio_cmd_pkg::REG_RX_PIPES:  resp = st_reg.snap.rx_pipes;
            radio_cmd_pkg::REG_STATUS:    resp = st_reg.snap.status;
            default:                      resp = 8'h00;
          endcase
        end
      end else if (lp_reg.cmd == radio_cmd_pkg::CMD_RX_WIDTH) begin
        resp = st_reg.snap.features ? st_reg.snap.width : 8'h00; // R5 R7
      end
    end
    if (lp_reg.bit_cnt == 3'h0) begin
      ns_next.cur  = resp;
      ns_next.miso = resp[7]; // R12
    end else if (lp_reg.nbytes == 2'h0) begin
      ns_next.miso = st_reg.snap.status[~lp_reg.bit_cnt]; // R2
    end else begin
      ns_next.miso = ns_reg.cur[~lp_reg.bit_cnt];
    end
  end

  // Bit counter dies with the frame; the hand-over word must outlive it
  always_ff @(posedge spi_sck_in or posedge spi_cs_n_in) begin
    if (spi_cs_n_in) begin
      lp_reg <= '0;
    end else begin
      lp_reg <= lp_next;
    end
  end

  always_ff @(posedge spi_sck_in or posedge reset_in) begin
    if (reset_in) begin
      rx_reg <= '0;
    end else begin
      rx_reg <= rx_next;
    end
  end

  always_ff @(negedge spi_sck_in or posedge reset_in) begin
    if (reset_in) begin
      ns_reg <= '0;
    end else begin
      ns_reg <= ns_next;
    end
  end

  // ****************************************
  // Command decode on the system clock
  // ****************************************
  always_comb begin
    st_next      = st_reg;
    st_next.cs_s = {st_reg.cs_s[2:0], ~spi_cs_n_in};
    st_next.tg_s = {st_reg.tg_s[1:0], rx_reg.tgl};
    byte_evt     = st_reg.tg_s[2] ^ st_reg.tg_s[1];
    // One stage later than the byte event so the last byte lands first
    frame_end    = st_reg.cs_s[3] && !st_reg.cs_s[2];
    is_ack       = st_reg.cmd[7:3] == radio_cmd_pkg::CMD_ACK_PAY_TOP;
    pay_ok       = (st_reg.cmd == radio_cmd_pkg::CMD_TX_PAY && !st_reg.cfg[radio_cmd_pkg::CFG_PRIMARY_ROLE_SELECT])
                 || (st_reg.cmd == radio_cmd_pkg::CMD_NOACK_TX && st_reg.features
                     && !st_reg.cfg[radio_cmd_pkg::CFG_PRIMARY_ROLE_SELECT]) // R5 R10
                 || (is_ack && st_reg.features && st_reg.cfg[radio_cmd_pkg::CFG_PRIMARY_ROLE_SELECT]
                     && st_reg.cmd[2:0] <= radio_cmd_pkg::PIPE_LAST_VALID // R8 R19
                     && st_reg.ack_cnt < radio_cmd_pkg::MAX_ACK_PENDING); // R9
    push         = 1'b0;
    push_w       = st_reg.stage;
    ack_inc      = 1'b0;
    if (byte_evt && rx_reg.first) begin
      st_next.cmd     = rx_reg.hold;
      st_next.dcnt    = 6'h00;
      st_next.stage_v = 1'b0;
      st_next.phase   = (rx_reg.hold == radio_cmd_pkg::CMD_STATUS_ONLY) ? radio_cmd_pkg::PH_SKIP
                                                                         : radio_cmd_pkg::PH_DATA; // R11
    end else if (byte_evt && st_reg.phase == radio_cmd_pkg::PH_DATA) begin
      if (st_reg.dcnt != 6'h3F) begin
        st_next.dcnt = st_reg.dcnt + 6'h01;
      end
      if (st_reg.cmd == radio_cmd_pkg::CMD_ACTIVATE && st_reg.dcnt == 6'h00) begin
        if (rx_reg.hold == radio_cmd_pkg::KEY_FEATURES) begin
          st_next.features = ~st_reg.features; // R3
        end
        if (rx_reg.hold == radio_cmd_pkg::KEY_BANK) begin
          st_next.bank = ~st_reg.bank; // R6
        end
      end
      if (st_reg.cmd[7:5] == radio_cmd_pkg::CMD_WRITE_TOP && st_reg.dcnt == 6'h00 && !st_reg.bank) begin
        unique case (st_reg.cmd[4:0])
          radio_cmd_pkg::REG_RADIO_CFG: st_next.cfg = rx_reg.hold & 8'h7F; // R13 R15 R16
          radio_cmd_pkg::REG_AUTO_ACKNOWLEDGE:   st_next.auto_acknowledge = rx_reg.hold & radio_cmd_pkg::PIPE_BITS; // R17
          radio_cmd_pkg::REG_RX_PIPES:  st_next.rx_pipes = rx_reg.hold & radio_cmd_pkg::PIPE_BITS;
          radio_cmd_pkg::REG_STATUS:    st_next.flags = st_reg.flags & ~rx_reg.hold[6:4];
          default:                      st_next.cfg = st_next.cfg;
        endcase
      end
      if (pay_ok && st_reg.dcnt < radio_cmd_pkg::MAX_PAYLOAD) begin
        push            = st_reg.stage_v; // R12
        push_w.last     = 1'b0;
        st_next.stage_v = 1'b1;
        st_next.stage   = {rx_reg.hold, st_reg.cmd[2:0], is_ack,
                           st_reg.cmd == radio_cmd_pkg::CMD_NOACK_TX, 1'b0}; // R8 R10
      end
    end
    if (frame_end) begin
      st_next.phase   = radio_cmd_pkg::PH_IDLE;
      st_next.stage_v = 1'b0;
      push            = st_reg.stage_v;
      push_w.last     = 1'b1;
      ack_inc         = st_reg.stage_v && st_reg.stage.ack && f_ready; // R9
    end
    // Set wins over a same-cycle clear
    st_next.flags = st_next.flags | {rx_ready_evt_in, tx_sent_evt_in, retry_evt_in};
    if (|st_next.auto_acknowledge[5:0]) begin
      st_next.cfg[radio_cmd_pkg::CFG_CRC_EN] = 1'b1; // R14
    end
    st_next.irq_n = ~|(st_next.flags & ~st_next.cfg[6:4]); // R13
    f_take        = !st_reg.out_v || pay_ready_in;
    ack_dec       = st_reg.out_v && pay_ready_in && st_reg.out_w.ack && st_reg.out_w.last;
    if (f_valid && f_take) begin
      st_next.out_v = 1'b1;
      st_next.out_w = f_data;
    end else if (pay_ready_in) begin
      st_next.out_v = 1'b0;
    end
    if (ack_inc && !ack_dec) begin
      st_next.ack_cnt = st_reg.ack_cnt + 2'h1;
    end else if (ack_dec && !ack_inc) begin
      st_next.ack_cnt = st_reg.ack_cnt - 2'h1;
    end
    // Refreshed only while no frame runs, so the link reads a frozen copy
    if (!st_reg.cs_s[1]) begin
      st_next.snap = {st_reg.bank, st_reg.flags, rx_pipe_in, !f_ready, st_reg.cfg,
                      st_reg.auto_acknowledge, st_reg.rx_pipes, rx_width_in, st_reg.features};
    end
    if (reset_in) begin
      st_next          = '0;
      st_next.phase    = radio_cmd_pkg::PH_IDLE;
      st_next.cfg      = radio_cmd_pkg::CFG_RST; // R14 R15 R16
      st_next.auto_acknowledge  = radio_cmd_pkg::AUTO_ACKNOWLEDGE_RST; // R17
      st_next.rx_pipes = radio_cmd_pkg::RX_PIPES_RST;
      st_next.irq_n    = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    st_reg <= st_next;
  end

  always_comb begin
    spi_miso_out       = ns_reg.miso;
    pay_valid_out      = st_reg.out_v;
    pay_word_out       = st_reg.out_w;
    irq_n_out          = st_reg.irq_n;
    power_up_out       = st_reg.cfg[radio_cmd_pkg::CFG_POWER_UP_BIT];
    primary_rx_out     = st_reg.cfg[radio_cmd_pkg::CFG_PRIMARY_ROLE_SELECT];
    crc_enable_out     = st_reg.cfg[radio_cmd_pkg::CFG_CRC_EN];
    crc_two_byte_out   = st_reg.cfg[radio_cmd_pkg::CFG_CRC_LEN];
    auto_acknowledge_enable_out = st_reg.auto_acknowledge[5:0];
    rx_pipe_enable_out = st_reg.rx_pipes[5:0];
    bank_out           = st_reg.bank;
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  property p_irq_rx;
    st_reg.flags[2] && !st_reg.cfg[radio_cmd_pkg::CFG_RX_MASK] |-> !irq_n_out;
  endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("rx flag unmasked but pin high"); // R13

  property p_irq_off;
    (st_reg.flags & ~st_reg.cfg[6:4]) == 3'h0 |-> irq_n_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("pin low with all sources masked"); // R13

  property p_crc_forced;
    |st_reg.auto_acknowledge[5:0] |-> crc_enable_out;
  endproperty
  a_crc_forced: assert property (p_crc_forced) else $error("crc off while auto-ack on"); // R14

  property p_reserved;
    st_reg.auto_acknowledge[7:6] == 2'h0 && st_reg.rx_pipes[7:6] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved pipe bits set"); // R17

  // Full pending count must refuse any further ack payload
  property p_ack_limit;
    st_reg.ack_cnt == radio_cmd_pkg::MAX_ACK_PENDING && is_ack |-> !pay_ok;
  endproperty
  a_ack_limit: assert property (p_ack_limit) else $error("too many ack payloads"); // R9

  property p_bank;
    byte_evt && !rx_reg.first && st_reg.phase == radio_cmd_pkg::PH_DATA && st_reg.dcnt == 6'h00
      && st_reg.cmd == radio_cmd_pkg::CMD_ACTIVATE && rx_reg.hold == radio_cmd_pkg::KEY_BANK
      |=> bank_out != $past(bank_out);
  endproperty
  a_bank: assert property (p_bank) else $error("bank did not toggle"); // R6

  property p_features;
    byte_evt && !rx_reg.first && st_reg.phase == radio_cmd_pkg::PH_DATA && st_reg.dcnt == 6'h00
      && st_reg.cmd == radio_cmd_pkg::CMD_ACTIVATE && rx_reg.hold == radio_cmd_pkg::KEY_FEATURES
      |=> st_reg.features != $past(st_reg.features);
  endproperty
  a_features: assert property (p_features) else $error("features did not toggle"); // R3

  property p_locked;
    !st_reg.features && st_reg.cmd != radio_cmd_pkg::CMD_TX_PAY |-> !pay_ok;
  endproperty
  a_locked: assert property (p_locked) else $error("locked command accepted"); // R5

  property p_bad_pipe;
    is_ack && st_reg.cmd[2:0] > radio_cmd_pkg::PIPE_LAST_VALID |-> !pay_ok;
  endproperty
  a_bad_pipe: assert property (p_bad_pipe) else $error("ack payload for bad pipe taken"); // R19

  property p_skip;
    byte_evt && rx_reg.first && rx_reg.hold == radio_cmd_pkg::CMD_STATUS_ONLY
      |=> st_reg.phase == radio_cmd_pkg::PH_SKIP ##1 !push [*2];
  endproperty
  a_skip: assert property (p_skip) else $error("status-only command did something"); // R11

  c_bank: cover property (bank_out ##1 !bank_out);
  c_ack_push: cover property (push && push_w.ack && push_w.last);
  c_irq: cover property (!irq_n_out);
  c_full: cover property (!f_ready);

endmodule
`default_nettype wire
